// ==== common/ifbc_pkg.sv ====
package ifbc_pkg;

    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_THR_LOW = 7'h07;
    localparam logic [6:0] ADDR_THR_HIGH = 7'h08;
    localparam logic [6:0] ADDR_BATCH_RATES = 7'h09;
    localparam logic [6:0] ADDR_AUX_MODE = 7'h0a;
    localparam logic [6:0] ADDR_CNT_CTRL = 7'h0b;
    localparam logic [6:0] ADDR_CNT_THR_LOW = 7'h0c;
    localparam logic [6:0] ADDR_LINE1_ROUTE = 7'h0d;
    localparam logic [6:0] ADDR_LINE2_ROUTE = 7'h0e;
    localparam logic [6:0] ADDR_SLAVE_BATCH = 7'h14;
    localparam logic [6:0] ADDR_STATUS1 = 7'h3a;
    localparam logic [6:0] ADDR_STATUS2 = 7'h3b;

    // ----------------------------------------------------------------
    // Writable bit masks and reset value
    // ----------------------------------------------------------------
    localparam logic [7:0] MASK_THR_HIGH = 8'h91;
    localparam logic [7:0] MASK_AUX_MODE = 8'hf7;
    localparam logic [7:0] MASK_CNT_CTRL = 8'h27;
    localparam logic [7:0] MASK_ROUTE = 8'h78;
    localparam logic [7:0] MASK_SLAVE_BATCH = 8'h0f;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_WTM8 = 0;
    localparam int BIT_CFG_CHANGE = 4;
    localparam int BIT_HALT = 7;
    localparam int BIT_CNT_SOURCE = 5;
    localparam int BIT_CNT_CLEAR = 6;
    localparam int BIT_ROUTE_TH = 3;
    localparam int BIT_ROUTE_OVR = 4;
    localparam int BIT_ROUTE_FULL = 5;
    localparam int BIT_ROUTE_CNT = 6;
    localparam int BIT_SPI_READ = 7;

    // ----------------------------------------------------------------
    // Sizes and decimation shifts
    // ----------------------------------------------------------------
    localparam logic [9:0] FIFO_DEPTH = 10'd512;
    localparam int RATE_W = 17;
    localparam int TS_SHIFT_DIV8 = 3;
    localparam int TS_SHIFT_DIV32 = 5;
    localparam logic [3:0] SPI_LAST_BIT = 4'hf;
    localparam logic [3:0] SPI_CMD_BIT = 4'h7;

    // ----------------------------------------------------------------
    // Rates in tenths of a hertz
    // ----------------------------------------------------------------
    localparam logic [16:0] RATE_OFF = 17'h00000;
    localparam logic [16:0] TEMP_RATE_1 = 17'd16;
    localparam logic [16:0] TEMP_RATE_2 = 17'd125;
    localparam logic [16:0] TEMP_RATE_3 = 17'd520;
    localparam logic [16:0] ACCEL_CODE11_RATE = 17'd16;
    localparam logic [16:0] GYRO_CODE11_RATE = 17'd65;

    // Serial frame states
    typedef enum logic [1:0] {
        IFBC_IDLE = 2'b00,
        IFBC_CMD = 2'b01,
        IFBC_DATA = 2'b11,
        IFBC_DONE = 2'b10
    } ifbc_spi_state_t;

    // Shared code table; code 11 is sensor specific
    function automatic logic [16:0] ifbc_batch_rate(
        input logic [3:0] code,
        input logic [16:0] code11_rate
    );
        case (code)
            4'h1: ifbc_batch_rate = 17'd125;
            4'h2: ifbc_batch_rate = 17'd260;
            4'h3: ifbc_batch_rate = 17'd520;
            4'h4: ifbc_batch_rate = 17'd1040;
            4'h5: ifbc_batch_rate = 17'd2080;
            4'h6: ifbc_batch_rate = 17'd4160;
            4'h7: ifbc_batch_rate = 17'd8330;
            4'h8: ifbc_batch_rate = 17'd16670;
            4'h9: ifbc_batch_rate = 17'd33330;
            4'ha: ifbc_batch_rate = 17'd66670;
            4'hb: ifbc_batch_rate = code11_rate;
            default: ifbc_batch_rate = 17'h00000;
        endcase
    endfunction

endpackage

// ==== dv/ifbc_host_model.sv ====
`timescale 1ns/100ps
module ifbc_host_model (
    // Clock
    input wire logic clk_i,
    // Serial lines toward the device
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    logic miso_w;

    // Released data line shows the inverse of the last driven bit
    assign miso_w = miso_oe_i ? miso_i : ~miso_i;

    // Idle lines: deselected, clock low
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end

    // One 16 bit frame, mode 0, MSB first, 16 sys cycles per half bit
    task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_o <= frm[i];
            repeat (16) @(posedge clk_i);
            sclk_o <= 1'b1;
            if (i < 8) rd = {rd[6:0], miso_w};
            repeat (16) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (16) @(posedge clk_i);
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
        repeat (8) @(posedge clk_i);
        #1;
    endtask
endmodule

// ==== dv/imu_fifo_batch_config_tb.sv ====
`timescale 1ns/100ps
module imu_fifo_batch_config_tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic cs_n, sclk, mosi, miso, miso_oe, full = 0, ovr = 0;
    logic [9:0] level = 10'h000;
    logic [3:0] ev = 4'h0;
    logic [3:0] s_rdy = 4'h0;
    logic [16:0] shub = 17'h186a0;
    logic fifo_wr, cfg_en, wm_flag, smp_flag, int1, int2;
    logic [9:0] depth;
    logic [3:0] slv_en;
    logic [2:0] mode;
    logic [16:0] a_rate, g_rate, ts_rate, t_rate;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [16:0] tbl [16] = '{17'h0, 17'h7d, 17'h104, 17'h208, 17'h410,
        17'h820, 17'h1040, 17'h208a, 17'h411e, 17'h8232, 17'h1046e, 17'h10,
        17'h0, 17'h0, 17'h0, 17'h0};
    logic [16:0] trate [4] = '{17'h0, 17'h10, 17'h7d, 17'h208};
    logic [16:0] tsr [4] = '{17'h0, 17'h186a0, 17'h30d4, 17'hc35};

    // Device under test and host partner
    ifbc_top u_dut (.SYS_CLK_I(sys_clk), .RESET_I(reset), .SPI_CS_N_I(cs_n),
        .SPI_SCLK_I(sclk), .SPI_MOSI_I(mosi), .SPI_MISO_O(miso),
        .SPI_MISO_OE_O(miso_oe), .FIFO_LEVEL_I(level), .FIFO_FULL_I(full),
        .FIFO_OVERRUN_I(ovr), .ACCEL_BATCH_I(ev[0]), .GYRO_BATCH_I(ev[1]),
        .ACCEL_DRDY_I(ev[2]), .GYRO_DRDY_I(ev[3]), .SLAVE_DRDY_I(s_rdy),
        .SHUB_RATE_I(shub), .FIFO_WRITE_O(fifo_wr), .DEPTH_LIMIT_O(depth),
        .CFG_CHANGE_EN_O(cfg_en), .SLAVE_BATCH_EN_O(slv_en),
        .FIFO_MODE_O(mode), .ACCEL_RATE_O(a_rate), .GYRO_RATE_O(g_rate),
        .TS_RATE_O(ts_rate), .TEMP_RATE_O(t_rate),
        .WATERMARK_FLAG_O(wm_flag), .SAMPLE_FLAG_O(smp_flag),
        .INT1_O(int1), .INT2_O(int2));
    ifbc_host_model u_host (.clk_i(sys_clk), .cs_n_o(cs_n), .sclk_o(sclk),
        .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));

    // Clock and hang guard
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] v;
        u_host.xfer({1'b0, a, d}, v);
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.xfer({1'b1, a, 8'h00}, v);
        chk(v, e);
    endtask

    // One cycle pulse on event and slave inputs, settled after launch
    task automatic pulse(input logic [3:0] m, input logic [3:0] s);
        @(posedge sys_clk) ev <= m;
        s_rdy <= s;
        @(posedge sys_clk) ev <= 4'h0;
        s_rdy <= 4'h0;
        #1;
    endtask

    task automatic t_reset();
        for (int a = 7; a <= 12; a++) rd_chk(7'(a), 8'h00);
        chk(depth, 17'h200);
    endtask

    task automatic t_wm();
        wr(7'h08, 8'hff);
        rd_chk(7'h08, 8'h91);
        wr(7'h07, 8'h23);
        chk(depth, 17'h123);
        chk(cfg_en, 17'h1);
        wr(7'h08, 8'h01);
        chk(depth, 17'h200);
        chk(cfg_en, 17'h0);
        @(posedge sys_clk) level <= 10'h122;
        tick(3);
        chk(wm_flag, 17'h0);
        @(posedge sys_clk) level <= 10'h123;
        tick(3);
        chk(wm_flag, 17'h1);
        rd_chk(7'h3a, 8'h23);
        rd_chk(7'h3b, 8'h81);
        @(posedge sys_clk) level <= 10'h000;
    endtask

    task automatic t_rates();
        for (int c = 0; c < 16; c++) begin
            wr(7'h09, {4'(c), 4'(c)});
            chk(a_rate, tbl[c]);
            chk(g_rate, (c == 11) ? 17'h41 : tbl[c]);
        end
        wr(7'h09, 8'h4a);
        chk(a_rate, 17'h1046e);
        chk(g_rate, 17'h410);
        for (int d = 0; d < 4; d++) begin
            wr(7'h0a, {2'(d), 2'(d), 2'b11, 2'(d)});
            rd_chk(7'h0a, {2'(d), 2'(d), 2'b01, 2'(d)});
            chk(mode, {1'b1, 2'(d)});
            chk(t_rate, trate[d]);
            chk(ts_rate, tsr[d]);
        end
        @(posedge sys_clk) shub <= 17'h0;
        tick(3);
        chk(ts_rate, 17'h823);
    endtask

    task automatic t_counter();
        wr(7'h0c, 8'h02);
        wr(7'h0b, 8'h21);
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 257; i++) pulse(4'h3, 4'h0);
            pulse(4'h1, 4'h0);
            tick(1);
            chk(smp_flag, 17'h0);
            pulse(4'h2, 4'h0);
            tick(1);
            chk(smp_flag, 17'h1);
            rd_chk(7'h3b, 8'h10);
            tick(1);
            chk(smp_flag, 17'h0);
            for (int i = 0; i < 5; i++) pulse(4'h2, 4'h0);
            wr(7'h0b, 8'h61);
            rd_chk(7'h0b, 8'h21);
        end
    endtask

    task automatic t_route();
        for (int e = 0; e < 3; e++) begin
            @(posedge sys_clk) full <= (e == 0);
            ovr <= (e == 1);
            level <= (e == 2) ? 10'h200 : 10'h000;
            for (int b = 3; b < 7; b++) begin
                wr(7'h0d, 8'(1 << b));
                wr(7'h0e, 8'h78 & ~8'(1 << b));
                tick(2);
                chk(int1, b == 5 - e);
                chk(int2, b != 5 - e);
            end
        end
    endtask

    task automatic t_write();
        wr(7'h14, 8'hf5);
        chk(slv_en, 17'h5);
        pulse(4'h4, 4'h0);
        chk(fifo_wr, 17'h1);
        pulse(4'h8, 4'h0);
        chk(fifo_wr, 17'h0);
        pulse(4'h0, 4'h2);
        chk(fifo_wr, 17'h0);
        pulse(4'h0, 4'h4);
        chk(fifo_wr, 17'h1);
        wr(7'h7f, 8'hff);
        rd_chk(7'h7f, 8'h00);
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        tick(8);
        t_reset();
        t_wm();
        t_rates();
        t_counter();
        t_route();
        t_write();
        final_report();
    end
endmodule

// ==== src/ifbc_sync.sv ====
`timescale 1ns/100ps
module ifbc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // Two stage synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= INIT;
            q_o <= INIT;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// ==== src/ifbc_top.sv ====
`timescale 1ns/100ps
// Operation
// - Watermark is nine bits over two registers
// - Watermark flag when level reaches threshold
// - Halt bit limits depth to watermark
// - Config change bit enables meta words
// - Accelerometer rate code decoded to tenths of a hertz
// - Gyroscope rate same table, code 11 differs
// - Gyro rate high nibble, accel low
// - Timestamp rate is max rate, decimated
// - Temperature rate from two bit code
// - Aux register field layout with mode
// - Counter clear bit clears, reads zero
// - Source bit picks accel or gyro events
// - Counter reaching threshold sets flag
// - Eleven bit threshold over two registers
// - Slave data batched only when enabled
// - Four events routable to either line
// - Status two read clears counter flag
// - FIFO write on fastest main or hub
module ifbc_top (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    // Serial register port
    input wire logic SPI_CS_N_I,
    input wire logic SPI_SCLK_I,
    input wire logic SPI_MOSI_I,
    output logic SPI_MISO_O,
    output logic SPI_MISO_OE_O,
    // FIFO core state and events
    input wire logic [9:0] FIFO_LEVEL_I,
    input wire logic FIFO_FULL_I,
    input wire logic FIFO_OVERRUN_I,
    input wire logic ACCEL_BATCH_I,
    input wire logic GYRO_BATCH_I,
    input wire logic ACCEL_DRDY_I,
    input wire logic GYRO_DRDY_I,
    input wire logic [3:0] SLAVE_DRDY_I,
    input wire logic [16:0] SHUB_RATE_I,
    // Batching control
    output logic FIFO_WRITE_O,
    output logic [9:0] DEPTH_LIMIT_O,
    output logic CFG_CHANGE_EN_O,
    output logic [3:0] SLAVE_BATCH_EN_O,
    output logic [2:0] FIFO_MODE_O,
    output logic [16:0] ACCEL_RATE_O,
    output logic [16:0] GYRO_RATE_O,
    output logic [16:0] TS_RATE_O,
    output logic [16:0] TEMP_RATE_O,
    // Flags and interrupt lines
    output logic WATERMARK_FLAG_O,
    output logic SAMPLE_FLAG_O,
    output logic INT1_O,
    output logic INT2_O
);
    // Assertions below share this clock and reset
    default clocking sys_cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RESET_I);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic cs_n_s;
    logic sclk_s;
    logic mosi_s;
    logic sclk_d_r;

    ifbc_sync #(.W(1), .INIT(1'b1)) u_sync_cs (
        .clk_i(SYS_CLK_I), .rst_i(RESET_I),
        .d_i(SPI_CS_N_I), .q_o(cs_n_s)
    );
    ifbc_sync #(.W(1), .INIT(1'b0)) u_sync_sclk (
        .clk_i(SYS_CLK_I), .rst_i(RESET_I),
        .d_i(SPI_SCLK_I), .q_o(sclk_s)
    );
    ifbc_sync #(.W(1), .INIT(1'b0)) u_sync_mosi (
        .clk_i(SYS_CLK_I), .rst_i(RESET_I),
        .d_i(SPI_MOSI_I), .q_o(mosi_s)
    );

    // ----------------------------------------------------------------
    // Serial frame engine
    // ----------------------------------------------------------------
    ifbc_pkg::ifbc_spi_state_t state_r;
    ifbc_pkg::ifbc_spi_state_t state_nxt;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_in_r;
    logic [7:0] shift_out_r;
    logic [6:0] addr_r;
    logic read_r;
    logic [7:0] rd_data;
    logic [7:0] in_byte;
    logic sclk_rise;
    logic sclk_fall;
    logic cmd_done;
    logic data_done;
    logic reg_we;
    logic stat2_rd;

    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;
    assign in_byte = {shift_in_r[6:0], mosi_s};
    assign cmd_done = (state_r == ifbc_pkg::IFBC_CMD) && sclk_rise
        && (bit_cnt_r == ifbc_pkg::SPI_CMD_BIT);
    assign data_done = (state_r == ifbc_pkg::IFBC_DATA) && sclk_rise
        && (bit_cnt_r == ifbc_pkg::SPI_LAST_BIT);
    assign reg_we = data_done && !read_r;
    assign stat2_rd = cmd_done && in_byte[ifbc_pkg::BIT_SPI_READ]
        && (in_byte[6:0] == ifbc_pkg::ADDR_STATUS2);

    // Next frame state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ifbc_pkg::IFBC_IDLE: if (!cs_n_s) state_nxt = ifbc_pkg::IFBC_CMD;
            ifbc_pkg::IFBC_CMD: if (cmd_done) state_nxt = ifbc_pkg::IFBC_DATA;
            ifbc_pkg::IFBC_DATA:
                if (data_done) state_nxt = ifbc_pkg::IFBC_DONE;
            ifbc_pkg::IFBC_DONE: state_nxt = ifbc_pkg::IFBC_DONE;
            default: state_nxt = ifbc_pkg::IFBC_IDLE;
        endcase
        if (cs_n_s) begin
            state_nxt = ifbc_pkg::IFBC_IDLE;
        end
    end

    // Frame state, bit count and input shifter
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            state_r <= ifbc_pkg::IFBC_IDLE;
            sclk_d_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            shift_in_r <= 8'h00;
            addr_r <= 7'h00;
            read_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sclk_d_r <= sclk_s;
            if (state_r == ifbc_pkg::IFBC_IDLE) begin
                bit_cnt_r <= 4'h0;
            end else if (sclk_rise) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                shift_in_r <= in_byte;
            end
            if (cmd_done) begin
                addr_r <= in_byte[6:0];
                read_r <= in_byte[ifbc_pkg::BIT_SPI_READ];
            end
        end
    end

    // Read data out, changed on falling clock
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            shift_out_r <= 8'h00;
            SPI_MISO_O <= 1'b0;
            SPI_MISO_OE_O <= 1'b0;
        end else begin
            SPI_MISO_OE_O <= !cs_n_s && read_r
                && (state_r == ifbc_pkg::IFBC_DATA);
            if (cmd_done) begin
                shift_out_r <= rd_data;
            end else if (sclk_fall && state_r == ifbc_pkg::IFBC_DATA) begin
                SPI_MISO_O <= shift_out_r[7];
                shift_out_r <= {shift_out_r[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [7:0] thr_low_r;
    logic [7:0] thr_high_r;
    logic [7:0] rates_r;
    logic [7:0] aux_r;
    logic [7:0] cnt_ctrl_r;
    logic [7:0] cnt_thr_low_r;
    logic [7:0] route1_r;
    logic [7:0] route2_r;
    logic [7:0] slave_en_r;
    logic [8:0] watermark_level;
    logic [10:0] sample_counter_threshold;

    assign watermark_level = {thr_high_r[ifbc_pkg::BIT_WTM8], thr_low_r};
    assign sample_counter_threshold = {cnt_ctrl_r[2:0], cnt_thr_low_r};

    // Register writes, reserved bits masked
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            thr_low_r <= ifbc_pkg::REG_RESET;
            thr_high_r <= ifbc_pkg::REG_RESET;
            rates_r <= ifbc_pkg::REG_RESET;
            aux_r <= ifbc_pkg::REG_RESET;
            cnt_ctrl_r <= ifbc_pkg::REG_RESET;
            cnt_thr_low_r <= ifbc_pkg::REG_RESET;
            route1_r <= ifbc_pkg::REG_RESET;
            route2_r <= ifbc_pkg::REG_RESET;
            slave_en_r <= ifbc_pkg::REG_RESET;
        end else if (reg_we) begin
            case (addr_r)
                ifbc_pkg::ADDR_THR_LOW: thr_low_r <= in_byte;
                ifbc_pkg::ADDR_THR_HIGH:
                    thr_high_r <= in_byte & ifbc_pkg::MASK_THR_HIGH;
                ifbc_pkg::ADDR_BATCH_RATES: rates_r <= in_byte;
                ifbc_pkg::ADDR_AUX_MODE:
                    aux_r <= in_byte & ifbc_pkg::MASK_AUX_MODE;
                ifbc_pkg::ADDR_CNT_CTRL:
                    cnt_ctrl_r <= in_byte & ifbc_pkg::MASK_CNT_CTRL;
                ifbc_pkg::ADDR_CNT_THR_LOW: cnt_thr_low_r <= in_byte;
                ifbc_pkg::ADDR_LINE1_ROUTE:
                    route1_r <= in_byte & ifbc_pkg::MASK_ROUTE;
                ifbc_pkg::ADDR_LINE2_ROUTE:
                    route2_r <= in_byte & ifbc_pkg::MASK_ROUTE;
                ifbc_pkg::ADDR_SLAVE_BATCH:
                    slave_en_r <= in_byte & ifbc_pkg::MASK_SLAVE_BATCH;
                default: thr_low_r <= thr_low_r;
            endcase
        end
    end

    // Read mux, unmapped reads zero
    always_comb begin
        case (in_byte[6:0])
            ifbc_pkg::ADDR_THR_LOW: rd_data = thr_low_r;
            ifbc_pkg::ADDR_THR_HIGH: rd_data = thr_high_r;
            ifbc_pkg::ADDR_BATCH_RATES: rd_data = rates_r;
            ifbc_pkg::ADDR_AUX_MODE: rd_data = aux_r;
            ifbc_pkg::ADDR_CNT_CTRL: rd_data = cnt_ctrl_r;
            ifbc_pkg::ADDR_CNT_THR_LOW: rd_data = cnt_thr_low_r;
            ifbc_pkg::ADDR_LINE1_ROUTE: rd_data = route1_r;
            ifbc_pkg::ADDR_LINE2_ROUTE: rd_data = route2_r;
            ifbc_pkg::ADDR_SLAVE_BATCH: rd_data = slave_en_r;
            ifbc_pkg::ADDR_STATUS1: rd_data = FIFO_LEVEL_I[7:0];
            ifbc_pkg::ADDR_STATUS2: rd_data = {WATERMARK_FLAG_O,
                FIFO_OVERRUN_I, FIFO_FULL_I, SAMPLE_FLAG_O, 2'b00,
                FIFO_LEVEL_I[9:8]};
            default: rd_data = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Batch-sample counter
    // ----------------------------------------------------------------
    logic [10:0] sample_cnt_r;
    logic [10:0] sample_cnt_nxt;
    logic [10:0] sample_cnt_inc;
    logic sample_flag_nxt;
    logic sample_counter_clear;
    logic count_event;
    logic count_hit;

    assign sample_counter_clear = reg_we
        && (addr_r == ifbc_pkg::ADDR_CNT_CTRL)
        && in_byte[ifbc_pkg::BIT_CNT_CLEAR];
    assign count_event = cnt_ctrl_r[ifbc_pkg::BIT_CNT_SOURCE]
        ? GYRO_BATCH_I : ACCEL_BATCH_I;
    assign sample_cnt_inc = sample_cnt_r + 11'h001;
    assign count_hit = count_event && !sample_counter_clear
        && (sample_cnt_inc == sample_counter_threshold);
    assign sample_cnt_nxt = (sample_counter_clear || count_hit) ? 11'h000
        : (count_event ? sample_cnt_inc : sample_cnt_r);
    assign sample_flag_nxt = count_hit
        || (SAMPLE_FLAG_O && !stat2_rd);

    // Counter and its sticky flag
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            sample_cnt_r <= 11'h000;
            SAMPLE_FLAG_O <= 1'b0;
        end else begin
            sample_cnt_r <= sample_cnt_nxt;
            SAMPLE_FLAG_O <= sample_flag_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Rate decode and batching outputs
    // ----------------------------------------------------------------
    logic [16:0] accel_batch_rate;
    logic [16:0] gyro_batch_rate;
    logic [16:0] max_rate;
    logic [16:0] ts_rate;
    logic [16:0] temp_rate;
    logic accel_faster;
    logic main_write;
    logic hub_write;
    logic wm_flag_nxt;
    logic [3:0] evt_vec;

    assign accel_batch_rate = ifbc_pkg::ifbc_batch_rate(rates_r[3:0],
        ifbc_pkg::ACCEL_CODE11_RATE);
    assign gyro_batch_rate = ifbc_pkg::ifbc_batch_rate(rates_r[7:4],
        ifbc_pkg::GYRO_CODE11_RATE);
    assign accel_faster = accel_batch_rate >= gyro_batch_rate;
    assign max_rate = (accel_faster ? accel_batch_rate : gyro_batch_rate)
        > SHUB_RATE_I ? (accel_faster ? accel_batch_rate : gyro_batch_rate)
        : SHUB_RATE_I;
    assign ts_rate = (aux_r[7:6] == 2'b01) ? max_rate
        : (aux_r[7:6] == 2'b10) ? (max_rate >> ifbc_pkg::TS_SHIFT_DIV8)
        : (aux_r[7:6] == 2'b11) ? (max_rate >> ifbc_pkg::TS_SHIFT_DIV32)
        : ifbc_pkg::RATE_OFF;
    assign temp_rate = (aux_r[5:4] == 2'b01) ? ifbc_pkg::TEMP_RATE_1
        : (aux_r[5:4] == 2'b10) ? ifbc_pkg::TEMP_RATE_2
        : (aux_r[5:4] == 2'b11) ? ifbc_pkg::TEMP_RATE_3
        : ifbc_pkg::RATE_OFF;
    assign main_write = (accel_batch_rate != ifbc_pkg::RATE_OFF
        || gyro_batch_rate != ifbc_pkg::RATE_OFF)
        && (accel_faster ? ACCEL_DRDY_I : GYRO_DRDY_I);
    assign hub_write = |(SLAVE_DRDY_I & slave_en_r[3:0]);
    assign wm_flag_nxt = FIFO_LEVEL_I >= {1'b0, watermark_level};
    assign evt_vec = {SAMPLE_FLAG_O, FIFO_FULL_I, FIFO_OVERRUN_I,
        WATERMARK_FLAG_O};

    // Registered control outputs
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            FIFO_WRITE_O <= 1'b0;
            DEPTH_LIMIT_O <= ifbc_pkg::FIFO_DEPTH;
            CFG_CHANGE_EN_O <= 1'b0;
            SLAVE_BATCH_EN_O <= 4'h0;
            FIFO_MODE_O <= 3'h0;
            ACCEL_RATE_O <= ifbc_pkg::RATE_OFF;
            GYRO_RATE_O <= ifbc_pkg::RATE_OFF;
            TS_RATE_O <= ifbc_pkg::RATE_OFF;
            TEMP_RATE_O <= ifbc_pkg::RATE_OFF;
            WATERMARK_FLAG_O <= 1'b0;
            INT1_O <= 1'b0;
            INT2_O <= 1'b0;
        end else begin
            FIFO_WRITE_O <= main_write || hub_write;
            DEPTH_LIMIT_O <= thr_high_r[ifbc_pkg::BIT_HALT]
                ? {1'b0, watermark_level} : ifbc_pkg::FIFO_DEPTH;
            CFG_CHANGE_EN_O <= thr_high_r[ifbc_pkg::BIT_CFG_CHANGE];
            SLAVE_BATCH_EN_O <= slave_en_r[3:0];
            FIFO_MODE_O <= aux_r[2:0];
            ACCEL_RATE_O <= accel_batch_rate;
            GYRO_RATE_O <= gyro_batch_rate;
            TS_RATE_O <= ts_rate;
            TEMP_RATE_O <= temp_rate;
            WATERMARK_FLAG_O <= wm_flag_nxt;
            INT1_O <= |(evt_vec & route1_r[6:3]);
            INT2_O <= |(evt_vec & route2_r[6:3]);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_clear_write;
        reg_we && addr_r == ifbc_pkg::ADDR_CNT_CTRL
            && in_byte[ifbc_pkg::BIT_CNT_CLEAR];
    endsequence
    sequence s_counter_idle;
        sample_cnt_r == 11'h000 && !cnt_ctrl_r[ifbc_pkg::BIT_CNT_CLEAR];
    endsequence

    a_wm_flag_level: assert property (
        !RESET_I |=> WATERMARK_FLAG_O == ($past(FIFO_LEVEL_I)
        >= {1'b0, $past(watermark_level)}))
        else $error("watermark flag wrong");
    a_depth_halt: assert property (
        thr_high_r[ifbc_pkg::BIT_HALT] |=> DEPTH_LIMIT_O[8:0]
        == $past(watermark_level) && !DEPTH_LIMIT_O[9])
        else $error("depth not limited");
    a_clear_self: assert property (
        s_clear_write |=> s_counter_idle)
        else $error("counter clear failed");
    a_hit_flag: assert property (
        count_event && !sample_counter_clear && sample_cnt_r + 11'h001
        == sample_counter_threshold |=> SAMPLE_FLAG_O && sample_cnt_r == 0)
        else $error("threshold flag missing");
    a_read_clears: assert property (
        stat2_rd && !count_hit |=> !SAMPLE_FLAG_O)
        else $error("flag not cleared on read");
    a_src_gyro: assert property (
        cnt_ctrl_r[ifbc_pkg::BIT_CNT_SOURCE] && !GYRO_BATCH_I
        && !sample_counter_clear |=> $stable(sample_cnt_r))
        else $error("counter moved without gyro event");
    a_slave_gate: assert property (
        !main_write && (SLAVE_DRDY_I & slave_en_r[3:0]) == 4'h0
        |=> !FIFO_WRITE_O)
        else $error("disabled slave batched");
    a_write_main: assert property (
        accel_batch_rate > gyro_batch_rate && ACCEL_DRDY_I
        |=> FIFO_WRITE_O)
        else $error("main write missing");
    a_reserved_zero: assert property (
        (thr_high_r & ~ifbc_pkg::MASK_THR_HIGH) == 8'h00
        && aux_r[3] == 1'b0 && cnt_ctrl_r[7:6] == 2'b00)
        else $error("reserved bit set");
    a_route_line2: assert property (
        route2_r[ifbc_pkg::BIT_ROUTE_TH] && WATERMARK_FLAG_O |=> INT2_O)
        else $error("line two not raised");
    a_ts_div32: assert property (
        aux_r[7:6] == 2'b11 |=> TS_RATE_O == ($past(max_rate) >> 5))
        else $error("timestamp decimation wrong");
endmodule
